// file: verilog/dpc_consts.vh
/*
  Constants for the dual event performance counter block: access indices,
  setup-register field positions, reset values and widths.
  Assumes it is included by bare name into the design files.
*/
//
// Contract
// - two independent 40-bit event/duration counters
// - duration mode adds one per true cycle
// - setup bits 7:0 hold event code
// - setup bits 15:8 hold qualifier mask
// - bit 16 counts at privilege 1-3
// - bit 17 counts at privilege 0
// - bit 18 counts rising transitions only
// - bit 19 pin per event, else overflow
// - pin pulse lasts exactly one bus clock
// - bit 20 raises overflow interrupt request
// - bit 22 in setup 0 enables both
// - bit 23 flips threshold test, ignored if zero
// - nonzero threshold: pass adds exactly one
// - zero threshold adds full event count
// - register instructions allowed only at privilege 0
// - user counter read gated by permit bit
// - counter write sign-extends bit 31 upward
// - counting starts after enabling write executes
// - stop both, or counter 1 alone
`ifndef DPC_CONSTS_VH
`define DPC_CONSTS_VH

// register access indices
`define DPC_IDX_SETUP0   2'h0
`define DPC_IDX_SETUP1   2'h1
`define DPC_IDX_CTR0     2'h2
`define DPC_IDX_CTR1     2'h3

// setup register fields
`define DPC_CODE_LSB     0
`define DPC_MASK_LSB     8
`define DPC_USR_BIT      16
`define DPC_OS_BIT       17
`define DPC_EDGE_BIT     18
`define DPC_PIN_BIT      19
`define DPC_INT_BIT      20
`define DPC_ON_BIT       22
`define DPC_FLIP_BIT     23
`define DPC_THR_LSB      24
`define DPC_THR_W        8
`define DPC_CFG_W        16

// writable bits; bit 21 reserved, bit 22 only in setup 0
`define DPC_SETUP0_WMASK 32'hFFDFFFFF
`define DPC_SETUP1_WMASK 32'hFF9FFFFF

// widths and reset values
`define DPC_CTR_W        40
`define DPC_SETUP_RST    32'h00000000
`define DPC_CTR_RST      40'h0000000000
`define DPC_BUS_DIV      4

`endif

// file: verilog/dpc_pin_pulse.v
/*
  Monitor pin pulse generator: each request not merged into a pending one drives the pin high for one
  bus clock (DIV core cycles) then low for one bus clock plus one core cycle.
  Assumes trigger comes from logic on the same core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dpc_pin_pulse #(
  parameter DIV = 4
) (
  // clock, reset, enable
  input  wire core_clk_in,
  input  wire rst_n_in,
  input  wire ce_in,
  // request and pin
  input  wire trig_in,
  output reg  pin_out
);
  reg [7:0] tick;
  reg       busy;
  reg       pend;

  // one request may wait while a pulse runs; later ones merge into it
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick    <= 8'h00;
      busy    <= 1'b0;
      pend    <= 1'b0;
      pin_out <= 1'b0;
    end else if (ce_in) begin
      if (busy) begin
        if (trig_in)
          pend <= 1'b1;
        if (tick == DIV[7:0] - 8'h01) begin
          pin_out <= 1'b0;
        end
        if (tick == 8'h02 * DIV[7:0] - 8'h01) begin
          tick <= 8'h00;
          busy <= 1'b0;
        end else begin
          tick <= tick + 8'h01;
        end
      end else if (trig_in || pend) begin
        busy    <= 1'b1;
        pend    <= 1'b0;
        pin_out <= 1'b1;
        tick    <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/dpc_perf_counters.v
/*
  Dual event performance counters: two setup registers, two 40-bit
  counters, privileged register access, user counter read, monitor pins
  and overflow interrupt requests.

  Counting: each core cycle, while the global flag in setup 0 is set and
  the counter's own setup word is nonzero, a counter adds one of
    - the privilege-filtered event count (zero threshold),
    - a single step when the threshold test passes (nonzero threshold),
    - a single step on a rising level (edge mode).
  Duration sources report one event per cycle in which they hold true.

  Register port: a request is answered one cycle later by ack or fault;
  read data reflects the state before the edge that takes the request.
  A counter write stores the low word and copies bit 31 upward, and wins
  over counting in the same cycle, hiding that cycle's overflow.

  User read port: open at any level unless the permit bit is set, which
  limits it to privilege 0.

  Monitor pins: each trigger gives one bus clock high (BUS_DIV core
  cycles) and one bus clock plus one core cycle low. Triggers during a pulse merge into one
  pending pulse, so in event mode the pin marks activity, not a count.

  Overflow requests: a one-cycle pulse on the carry out of the top bit,
  when the counter's interrupt flag is set.

  Assumes event units outside report per-cycle event counts on the core
  clock and the privilege level is supplied by the core each cycle.
  Assumes the permit bit and privilege level come from logic on the same
  clock, so neither passes a synchroniser here.
  Assumes the reset pin may be asynchronous; its release is retimed.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dpc_consts.vh"
module dpc_perf_counters #(
  parameter EVT_W   = 4,
  parameter BUS_DIV = `DPC_BUS_DIV
) (
  // clock, reset, enable
  input  wire              core_clk_in,
  input  wire              rst_b_in,
  input  wire              ce_in,
  // processor state
  input  wire [1:0]        cpl_in,
  input  wire              user_read_permit_in,
  // register instruction port
  input  wire              msr_req_in,
  input  wire              msr_wr_in,
  input  wire [1:0]        msr_idx_in,
  input  wire [31:0]       msr_wdata_in,
  output reg               msr_ack_out,
  output reg               msr_fault_out,
  output reg  [39:0]       msr_rdata_out,
  // user counter read port
  input  wire              pmc_req_in,
  input  wire              pmc_sel_in,
  output reg               pmc_ack_out,
  output reg               pmc_fault_out,
  output reg  [39:0]       pmc_rdata_out,
  // event units
  input  wire [EVT_W-1:0]  evt_num0_in,
  input  wire [EVT_W-1:0]  evt_num1_in,
  output wire [15:0]       evt_cfg0_out,
  output wire [15:0]       evt_cfg1_out,
  // monitor pins and overflow requests
  output wire              monitor_pin0_out,
  output wire              monitor_pin1_out,
  output wire              ovf_irq0_out,
  output wire              ovf_irq1_out
);
  // counter width is fixed by the register layout, not a parameter
  localparam CW = `DPC_CTR_W;

  // reset release through two flops; assertion stays asynchronous so
  // the block clears even without a running clock, while release is
  // retimed to avoid a partial start across the counters
  reg rst_meta;
  reg rst_n;
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // architectural setup registers
  reg  [31:0] event_setup_0;
  reg  [31:0] event_setup_1;
  // counter values and per-counter outputs gathered from the loop
  wire [2*CW-1:0] cnt_flat;
  wire [1:0] irq_flat;
  wire [1:0] pin_flat;

  // register access needs privilege level 0
  wire msr_ok = msr_req_in && (cpl_in == 2'h0);
  wire wr_ok  = msr_ok && msr_wr_in;

  // the global enable lives only in setup 0
  wire glob_on = event_setup_0[`DPC_ON_BIT];

  // setup register writes; reserved bits and the missing global flag of
  // setup 1 are masked so they always read back as zero
  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      event_setup_0 <= `DPC_SETUP_RST;
      event_setup_1 <= `DPC_SETUP_RST;
    end else if (ce_in) begin
      if (wr_ok && msr_idx_in == `DPC_IDX_SETUP0)
        event_setup_0 <= msr_wdata_in & `DPC_SETUP0_WMASK;
      if (wr_ok && msr_idx_in == `DPC_IDX_SETUP1)
        event_setup_1 <= msr_wdata_in & `DPC_SETUP1_WMASK;
    end
  end

  // code and qualifier mask steer the outside event units; they see a
  // new setup from the cycle after its write
  assign evt_cfg0_out = event_setup_0[`DPC_CODE_LSB +: `DPC_CFG_W];
  assign evt_cfg1_out = event_setup_1[`DPC_CODE_LSB +: `DPC_CFG_W];

  wire [63:0] setup_flat = {event_setup_1, event_setup_0};
  wire [2*EVT_W-1:0] num_flat = {evt_num1_in, evt_num0_in};

  // per-counter datapath; one body serves both counters so that their
  // behaviour cannot drift apart. Counter 0 sits at slice 0 of the flat
  // buses, counter 1 at slice 1.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ctr
      // this counter's setup word and event report
      wire [31:0]      setup   = setup_flat[32*g +: 32];
      wire [EVT_W-1:0] num     = num_flat[EVT_W*g +: EVT_W];
      // decoded setup fields
      wire [7:0]       thr     = setup[`DPC_THR_LSB +: `DPC_THR_W];
      wire             usr_en  = setup[`DPC_USR_BIT];
      wire             os_en   = setup[`DPC_OS_BIT];
      wire             edge_en = setup[`DPC_EDGE_BIT];
      wire             pin_ev  = setup[`DPC_PIN_BIT];
      wire             int_en  = setup[`DPC_INT_BIT];
      wire             flip    = setup[`DPC_FLIP_BIT];
      // write strobe for this counter's own index
      wire [1:0]       my_idx  = (g == 0) ? `DPC_IDX_CTR0 : `DPC_IDX_CTR1;
      wire             wr_hit  = wr_ok && (msr_idx_in == my_idx);
      // counter state
      reg  [CW-1:0]    count;
      reg              prev_hit;
      reg              irq;
      // per-cycle terms
      reg              priv_ok;
      reg  [7:0]       qual;
      reg              run;
      reg              thr_pass;
      reg              hit;
      reg  [CW-1:0]    lvl_inc;
      reg  [CW-1:0]    inc;
      reg  [CW:0]      sum;
      reg  [CW-1:0]    next_count;
      reg              carry;
      reg              next_pin;

      // privilege filter: events outside the enabled levels count as none;
      // both flags together count at every level
      always @* begin
        priv_ok = (cpl_in == 2'h0) ? os_en
                                   : usr_en;
        qual = 8'h00;
        if (priv_ok)
          qual[EVT_W-1:0] = num;
      end

      // clearing a setup register stops its counter; the global flag in
      // setup 0 stops both
      always @* begin
        run = glob_on && (setup != 32'h00000000);
      end

      // threshold test; the flip flag is meaningless with a zero threshold
      always @* begin
        if (thr == 8'h00)
          thr_pass = 1'b0;
        else if (flip)
          thr_pass = (qual < thr);
        else
          thr_pass = (qual >= thr);
      end

      // level for the edge detector and the plain per-cycle increment
      always @* begin
        if (thr != 8'h00) begin
          hit     = thr_pass;
          lvl_inc = thr_pass ? {{(CW-1){1'b0}}, 1'b1} : {CW{1'b0}};
        end else begin
          hit     = (qual != 8'h00);
          // duration sources report one per true cycle
          lvl_inc = {{(CW-8){1'b0}}, qual};
        end
      end

      // edge mode gives one step per rising level; a level that stays up
      // counts once, a limitation users must expect
      always @* begin
        if (edge_en)
          inc = (hit && !prev_hit) ? {{(CW-1){1'b0}}, 1'b1}
                                   : {CW{1'b0}};
        else
          inc = lvl_inc;
        if (!run)
          inc = {CW{1'b0}};
      end

      // one extra bit on the adder so the carry out of bit 39 is the
      // overflow; the sum simply wraps and counting carries on
      always @* begin
        sum        = {1'b0, count} + {1'b0, inc};
        next_count = sum[CW-1:0];
        carry      = sum[CW];
        next_pin   = pin_ev ? (inc != {CW{1'b0}})
                            : carry;
      end

      // counter, edge history and overflow request
      always @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          count    <= `DPC_CTR_RST;
          prev_hit <= 1'b0;
          irq      <= 1'b0;
        end else if (ce_in) begin
          // a write wins over counting in the same cycle
          if (wr_hit)
            count <= {{(CW-32){msr_wdata_in[31]}}, msr_wdata_in};
          else
            count <= next_count;
          // history only runs while counting, so a restart sees a fresh edge
          prev_hit <= run && hit;
          // the write also hides an overflow that would land in its cycle
          irq      <= !wr_hit && carry && int_en;
        end
      end

      // an idle pin rises on the same edge as the count changes; the pulse
      // stretcher keeps its own pending flag, so a burst of triggers
      // costs at most one extra pulse
      dpc_pin_pulse #(
        .DIV (BUS_DIV)
      ) dpc_pin_pulse_i (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n),
        .ce_in       (ce_in),
        .trig_in     (next_pin && !wr_hit),
        .pin_out     (pin_flat[g])
      );

      assign cnt_flat[CW*g +: CW] = count;
      assign irq_flat[g] = irq;
    end
  endgenerate

  // pins and requests leave straight from the flops inside the loop,
  // so no glitch reaches the outside
  assign monitor_pin0_out = pin_flat[0];
  assign monitor_pin1_out = pin_flat[1];
  assign ovf_irq0_out     = irq_flat[0];
  assign ovf_irq1_out     = irq_flat[1];

  // read data for the register instruction port; setup reads fill the
  // upper byte with zero, counter reads return all 40 bits as they stand
  // before the edge that takes the request
  reg [39:0] msr_rd;
  always @* begin
    case (msr_idx_in)
      `DPC_IDX_SETUP0: msr_rd = {8'h00, event_setup_0};
      `DPC_IDX_SETUP1: msr_rd = {8'h00, event_setup_1};
      `DPC_IDX_CTR0:   msr_rd = cnt_flat[CW-1:0];
      `DPC_IDX_CTR1:   msr_rd = cnt_flat[2*CW-1:CW];
      default:         msr_rd = 40'h0000000000;
    endcase
  end

  // register port answer: ack or fault one cycle after the request,
  // never both; a refused access returns zero so nothing leaks to a
  // lower privilege level
  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      msr_ack_out   <= 1'b0;
      msr_fault_out <= 1'b0;
      msr_rdata_out <= 40'h0000000000;
    end else if (ce_in) begin
      msr_ack_out   <= msr_ok;
      msr_fault_out <= msr_req_in && !msr_ok;
      // read data only with an acknowledged read; writes answer zero
      if (msr_ok && !msr_wr_in)
        msr_rdata_out <= msr_rd;
      else
        msr_rdata_out <= 40'h0000000000;
    end
  end

  // user counter read: not ordered with a register write in the same
  // cycle, so it sees the older value
  always @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pmc_ack_out   <= 1'b0;
      pmc_fault_out <= 1'b0;
      pmc_rdata_out <= 40'h0000000000;
    end else if (ce_in) begin
      pmc_ack_out   <= 1'b0;
      pmc_fault_out <= 1'b0;
      pmc_rdata_out <= 40'h0000000000;
      if (pmc_req_in) begin
        // permit bit set limits the read to privilege 0
        if (user_read_permit_in && cpl_in != 2'h0) begin
          pmc_fault_out <= 1'b1;
        end else begin
          pmc_ack_out   <= 1'b1;
          pmc_rdata_out <= pmc_sel_in ? cnt_flat[2*CW-1:CW]
                                      : cnt_flat[CW-1:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/dpc_perf_counters_sva.sv
/*
  Checker for the dual event counter block: port-level assertions.
  Assumes one core clock and a bus clock of four core cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module dpc_perf_counters_sva #(
  parameter BUS_DIV = 4
) (
  input wire logic        core_clk_in,
  input wire logic        rst_b_in,
  input wire logic        ce_in,
  input wire logic [1:0]  cpl_in,
  input wire logic        user_read_permit_in,
  input wire logic        msr_req_in,
  input wire logic        msr_wr_in,
  input wire logic [1:0]  msr_idx_in,
  input wire logic [31:0] msr_wdata_in,
  input wire logic        msr_ack_out,
  input wire logic        msr_fault_out,
  input wire logic        pmc_req_in,
  input wire logic        pmc_ack_out,
  input wire logic        pmc_fault_out,
  input wire logic [15:0] evt_cfg0_out,
  input wire logic [15:0] evt_cfg1_out,
  input wire logic        monitor_pin0_out,
  input wire logic        ovf_irq0_out
);
  // qualified requests; only privilege 0 may touch registers
  wire go = msr_req_in && ce_in;
  wire p0 = cpl_in == 2'h0;
  wire wr_go = go && msr_wr_in;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  AST_MSR_ACK: assert property (go && p0 |=> msr_ack_out && !msr_fault_out)
    else $error("register access not acknowledged");
  AST_MSR_FAULT: assert property (go && !p0 |=> msr_fault_out && !msr_ack_out)
    else $error("unprivileged register access not refused");
  AST_FAULT_NOWR: assert property (wr_go && !p0 && msr_idx_in == 2'h0 |=> $stable(evt_cfg0_out))
    else $error("refused write changed setup 0");
  AST_CFG0: assert property (wr_go && p0 && msr_idx_in == 2'h0 |=> evt_cfg0_out == $past(msr_wdata_in[15:0]))
    else $error("setup 0 code and mask not taken");
  AST_CFG1: assert property (wr_go && p0 && msr_idx_in == 2'h1 |=> evt_cfg1_out == $past(msr_wdata_in[15:0]))
    else $error("setup 1 code and mask not taken");
  AST_PMC_OPEN: assert property (pmc_req_in && ce_in && (!user_read_permit_in || p0) |=> pmc_ack_out && !pmc_fault_out)
    else $error("user counter read not answered");
  AST_PMC_SHUT: assert property (pmc_req_in && ce_in && user_read_permit_in && !p0 |=> pmc_fault_out && !pmc_ack_out)
    else $error("user counter read not refused");
  AST_PIN_PULSE: assert property ($rose(monitor_pin0_out) |-> monitor_pin0_out[*4] ##1 !monitor_pin0_out[*4])
    else $error("monitor pin pulse not one bus clock");
  AST_IRQ_ONE: assert property (ovf_irq0_out |=> !ovf_irq0_out)
    else $error("overflow request longer than one cycle");
  // main scenarios
  COV_FAULT: cover property (msr_fault_out);
  COV_IRQ: cover property (ovf_irq0_out);
  COV_PIN: cover property ($rose(monitor_pin0_out));
endmodule
bind dpc_perf_counters dpc_perf_counters_sva #(.BUS_DIV(BUS_DIV)) dpc_perf_counters_sva_i (
  .core_clk_in, .rst_b_in, .ce_in, .cpl_in, .user_read_permit_in, .msr_req_in, .msr_wr_in,
  .msr_idx_in, .msr_wdata_in, .msr_ack_out, .msr_fault_out, .pmc_req_in, .pmc_ack_out,
  .pmc_fault_out, .evt_cfg0_out, .evt_cfg1_out, .monitor_pin0_out, .ovf_irq0_out);
`default_nettype wire

// file: verif/dpc_perf_counters_test.sv
/*
  Testbench for the dual event counter block: register and user read tasks,
  a table of counting modes, overflow and pin checks.
  Assumes BUS_DIV of 4; inputs change at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module dpc_perf_counters_test;
  logic        core_clk_in = 1'b0;
  logic        ce_in = 1'b1;
  logic        rst_b_in = 1'b0;
  logic [1:0]  cpl_in = 2'h0;
  logic        user_read_permit_in = 1'b0;
  logic        msr_req_in = 1'b0, msr_wr_in = 1'b0, pmc_req_in = 1'b0, pmc_sel_in = 1'b0;
  logic [1:0]  msr_idx_in = 2'h0;
  logic [31:0] msr_wdata_in = 32'h0;
  logic [3:0]  evt_num0_in = 4'h0, evt_num1_in = 4'h0;
  wire         msr_ack_out, msr_fault_out, pmc_ack_out, pmc_fault_out;
  wire         monitor_pin0_out, ovf_irq0_out, monitor_pin1_out, ovf_irq1_out;
  wire [15:0]  evt_cfg0_out, evt_cfg1_out;
  wire [39:0]  msr_rdata_out, pmc_rdata_out;
  integer      n_fail = 0, n_tests = 0, pin_hi = 0, irq_hi = 0, i, p, r;
  integer      pin1_hi = 0, irq1_hi = 0, p1, r1;
  logic [39:0] q;
  // counting table: setups, privilege, events per cycle, expected counts
  logic [31:0] s0t [10] = '{32'h00430000, 32'h02430000, 32'h02430000, 32'h02C30000,
    32'h00C30000, 32'h00420000, 32'h00410000, 32'h00410000, 32'h00470000, 32'h00030000};
  logic [31:0] s1t [10] = '{32'h0, 32'h00030000, 32'h00030000, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h00030000};
  logic [1:0]  ct [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0};
  logic [3:0]  nt [10] = '{4'h3, 4'h3, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'h1, 4'h1};
  logic [7:0]  e0t [10] = '{8'hF, 8'h5, 8'h0, 8'h5, 8'hA, 8'h0, 8'hA, 8'h0, 8'h1, 8'h0};
  logic [7:0]  e1t [10] = '{8'h0, 8'hF, 8'h5, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};

  dpc_perf_counters #(.EVT_W(4), .BUS_DIV(4)) dpc_perf_counters_i (
    .core_clk_in, .rst_b_in, .ce_in, .cpl_in, .user_read_permit_in, .msr_req_in,
    .msr_wr_in, .msr_idx_in, .msr_wdata_in, .msr_ack_out, .msr_fault_out, .msr_rdata_out,
    .pmc_req_in, .pmc_sel_in, .pmc_ack_out, .pmc_fault_out, .pmc_rdata_out, .evt_num0_in,
    .evt_num1_in, .evt_cfg0_out, .evt_cfg1_out, .monitor_pin0_out,
    .monitor_pin1_out, .ovf_irq0_out, .ovf_irq1_out);

  always #2.5 core_clk_in = ~core_clk_in;
  // pulse widths tallied, so merged pulses show up as extra high cycles
  always @(negedge core_clk_in) begin
    pin_hi += monitor_pin0_out;
    irq_hi += ovf_irq0_out;
    pin1_hi += monitor_pin1_out;
    irq1_hi += ovf_irq1_out;
  end

  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one register access; events drop to zero as it is issued
  task automatic msr(input logic w, input logic [1:0] ix, input logic [31:0] d,
                     input logic [1:0] c, output logic [39:0] rq);
    @(negedge core_clk_in);
    {msr_req_in, msr_wr_in, msr_idx_in, msr_wdata_in, cpl_in} = {1'b1, w, ix, d, c};
    {evt_num0_in, evt_num1_in} = 8'h0;
    @(negedge core_clk_in);
    msr_req_in = 1'b0;
    chk("msr_ack_out", 40'(c == 2'h0), 40'(msr_ack_out));
    chk("msr_fault_out", 40'(c != 2'h0), 40'(msr_fault_out));
    rq = msr_rdata_out;
  endtask
  task automatic pmc(input logic s, input logic f, input logic [39:0] e);
    @(negedge core_clk_in);
    {pmc_req_in, pmc_sel_in} = {1'b1, s};
    @(negedge core_clk_in);
    pmc_req_in = 1'b0;
    chk("pmc_fault_out", 40'(f), 40'(pmc_fault_out));
    chk("pmc_ack_out", 40'(!f), 40'(pmc_ack_out));
    chk("pmc_rdata_out", e, pmc_rdata_out);
  endtask
  // five counted edges: four here plus the one before the next access
  task automatic burst(input logic [3:0] n, input logic [1:0] c);
    {evt_num0_in, evt_num1_in, cpl_in} = {n, n, c};
    repeat (4) @(negedge core_clk_in);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #50000;
    n_fail++;
    final_report;
  end

  initial begin
    repeat (4) @(negedge core_clk_in);
    rst_b_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    for (i = 0; i < 4; i++) begin
      msr(1'b0, i[1:0], 32'h0, 2'h0, q);
      chk("reset value", 40'h0, q);
    end
    msr(1'b1, 2'h0, 32'h00430000, 2'h3, q);
    msr(1'b0, 2'h0, 32'h0, 2'h0, q);
    chk("event_setup_0", 40'h0, q);
    msr(1'b1, 2'h1, 32'hFFFFFFFF, 2'h0, q);
    chk("evt_cfg1_out", 40'hFFFF, 40'(evt_cfg1_out));
    msr(1'b0, 2'h1, 32'h0, 2'h0, q);
    chk("event_setup_1", 40'h00FF9FFFFF, q);
    msr(1'b1, 2'h1, 32'h0, 2'h0, q);
    msr(1'b1, 2'h3, 32'h80000005, 2'h0, q);
    msr(1'b0, 2'h3, 32'h0, 2'h0, q);
    chk("event_counter_1", 40'hFF80000005, q);
    msr(1'b1, 2'h3, 32'h7FFFFFFF, 2'h0, q);
    cpl_in = 2'h3;
    pmc(1'b1, 1'b0, 40'h007FFFFFFF);
    user_read_permit_in = 1'b1;
    pmc(1'b1, 1'b1, 40'h0);
    cpl_in = 2'h0;
    pmc(1'b1, 1'b0, 40'h007FFFFFFF);
    user_read_permit_in = 1'b0;
    // counter 0 cleared last so idle cycles never leak into it
    for (i = 0; i < 10; i++) begin
      msr(1'b1, 2'h1, s1t[i], 2'h0, q);
      msr(1'b1, 2'h0, s0t[i], 2'h0, q);
      msr(1'b1, 2'h3, 32'h0, 2'h0, q);
      msr(1'b1, 2'h2, 32'h0, 2'h0, q);
      burst(nt[i], ct[i]);
      msr(1'b0, 2'h2, 32'h0, 2'h0, q);
      chk("event_counter_0", 40'(e0t[i]), q);
      msr(1'b0, 2'h3, 32'h0, 2'h0, q);
      chk("event_counter_1", 40'(e1t[i]), q);
    end
    msr(1'b1, 2'h0, 32'h005312A5, 2'h0, q);
    chk("evt_cfg0_out", 40'h12A5, 40'(evt_cfg0_out));
    msr(1'b1, 2'h1, 32'h00130000, 2'h0, q);
    msr(1'b1, 2'h2, 32'hFFFFFFFF, 2'h0, q);
    msr(1'b1, 2'h3, 32'hFFFFFFFF, 2'h0, q);
    {p, r, p1, r1} = {pin_hi, irq_hi, pin1_hi, irq1_hi};
    burst(4'h1, 2'h0);
    msr(1'b0, 2'h2, 32'h0, 2'h0, q);
    chk("event_counter_0", 40'h4, q);
    repeat (30) @(negedge core_clk_in);
    chk("ovf_irq0_out pulses", 40'h1, 40'(irq_hi - r));
    chk("monitor_pin0_out high", 40'h4, 40'(pin_hi - p));
    chk("ovf_irq1_out pulses", 40'h1, 40'(irq1_hi - r1));
    chk("monitor_pin1_out high", 40'h4, 40'(pin1_hi - p1));
    msr(1'b1, 2'h0, 32'h004B0000, 2'h0, q);
    msr(1'b1, 2'h2, 32'h0, 2'h0, q);
    {p, r, p1, r1} = {pin_hi, irq_hi, pin1_hi, irq1_hi};
    burst(4'h1, 2'h0);
    msr(1'b0, 2'h2, 32'h0, 2'h0, q);
    chk("event_counter_0", 40'h5, q);
    repeat (30) @(negedge core_clk_in);
    chk("monitor_pin0_out high", 40'h8, 40'(pin_hi - p));
    chk("ovf_irq0_out pulses", 40'h0, 40'(irq_hi - r));
    chk("ovf_irq1_out pulses", 40'h0, 40'(irq1_hi - r1));
    chk("monitor_pin1_out high", 40'h0, 40'(pin1_hi - p1));
    // a low clock enable holds the counters despite live events
    ce_in = 1'b0;
    {evt_num0_in, evt_num1_in} = 8'h33;
    repeat (4) @(negedge core_clk_in);
    {ce_in, evt_num0_in, evt_num1_in} = {1'b1, 8'h0};
    msr(1'b0, 2'h2, 32'h0, 2'h0, q);
    chk("event_counter_0 frozen", 40'h5, q);
    final_report;
  end
endmodule
`default_nettype wire
